// ==== rtl/udc_counter_top.sv ====
// Up/down event counter with threshold-driven switching output
// Function
// - While clear is high the count is zero and the output low.
// - While clear stays high pulse edges are ignored, output held at 0.
// - Only rising edges of the pulse input are counted.
// - Direction 0 counts up, direction 1 counts down.
// - Each counted edge moves the count by exactly one, except that it holds at zero and at CNT_MAX.
// - A configurable start value is loaded and counting begins there.
// - With retention on, count and output survive a reset.
// - Set >= clear: high at count >= set, low below clear, else hold.
// - Set < clear: high only inside the threshold window, else low.
// - Thresholds are compared only once per scan cycle.
// - New thresholds and count are accepted while running.
`timescale 1ns/1ps
module udc_counter_top
  import udc_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS,
  parameter logic [CNT_W-1:0] START_DEFAULT = 27'h0000000,
  parameter logic [CNT_W-1:0] SET_DEFAULT   = 27'h0000000,
  parameter logic [CNT_W-1:0] CLR_DEFAULT   = 27'h0000000,
  parameter logic RETAIN_DEFAULT = 1'b0
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  // Register port
  input  wire udc_pkg::udc_bus_req_t        bus_req,
  output      logic [udc_pkg::DATA_W-1:0]   rd_data,
  // Counter pins
  input  wire logic                         pulse_in,
  input  wire logic                         dir_in,
  input  wire logic                         clear_in,
  // Thresholds from another function block
  input  wire logic [udc_pkg::CNT_W-1:0]    ext_set_thr,
  input  wire logic [udc_pkg::CNT_W-1:0]    ext_clr_thr,
  // Results
  output      logic                         switch_out,
  output      logic [udc_pkg::CNT_W-1:0]    count_out
);

  import udc_pkg::*;

  // ---------------------------------------------------------------
  // Constants and helpers
  // ---------------------------------------------------------------
  localparam int SCAN_W = $clog2(SCAN_CYCLES + 1);
  localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(SCAN_CYCLES - 1);
  localparam logic [SCAN_W-1:0] SCAN_ZERO = '0;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 27'h0000001;

  // Pick a register or the external value as a threshold
  function automatic logic [CNT_W-1:0] pick_thr(
    input logic             use_ext,
    input logic [CNT_W-1:0] reg_val,
    input logic [CNT_W-1:0] ext_val
  );
    pick_thr = use_ext ? ext_val : reg_val;
  endfunction

  // Clamp a written value into the count range
  function automatic logic [CNT_W-1:0] clamp_cnt(
    input logic [DATA_W-1:0] val
  );
    clamp_cnt = (val > DATA_W'(CNT_MAX)) ? CNT_MAX : val[CNT_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  udc_state_t        state;
  udc_state_t        next_state;
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  set_thr;
  logic [CNT_W-1:0]  clr_thr;
  logic [CNT_W-1:0]  start_val;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic              next_q;
  logic [SCAN_W-1:0] scan_cnt;
  logic              pulse_prev;
  logic              mark_ok;
  logic              keep_sel;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_lvl;
  logic             pulse_lvl;
  logic             dir_lvl;
  logic             clear_lvl;

  assign pin_raw = {clear_in, dir_in, pulse_in};

  udc_pin_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   (pin_raw),
    .level    (pin_lvl)
  );

  assign pulse_lvl = pin_lvl[PIN_PULSE];
  assign dir_lvl   = pin_lvl[PIN_DIR];
  assign clear_lvl = pin_lvl[PIN_CLEAR];

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_set;
  logic wr_clr;
  logic wr_start;
  logic wr_count;
  logic load_start;
  logic running;

  assign running    = (state == ST_RUN);
  assign wr_ctrl    = bus_req.wr && (bus_req.addr == ADR_CTRL);
  assign wr_set     = bus_req.wr && (bus_req.addr == ADR_SET_THR);
  assign wr_clr     = bus_req.wr && (bus_req.addr == ADR_CLR_THR);
  assign wr_start   = bus_req.wr && (bus_req.addr == ADR_START);
  assign wr_count   = bus_req.wr && (bus_req.addr == ADR_COUNT);
  assign load_start = wr_ctrl && bus_req.wdata[CTRL_LOAD];

  // Configuration registers, accepted while running
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= CTRL_RESET;
      set_thr   <= SET_DEFAULT;
      clr_thr   <= CLR_DEFAULT;
      start_val <= START_DEFAULT;
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus_req.wdata[CTRL_W-1:0];
      end
      if (wr_set) begin
        set_thr <= clamp_cnt(bus_req.wdata);
      end
      if (wr_clr) begin
        clr_thr <= clamp_cnt(bus_req.wdata);
      end
      if (wr_start) begin
        start_val <= clamp_cnt(bus_req.wdata);
      end
    end
  end

  // Retention enable: reset value comes from the parameter
  logic retain_en;
  logic retain_flip;

  assign retain_en = ctrl[CTRL_RETAIN] ^ retain_flip;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      retain_flip <= RETAIN_DEFAULT;
    end else begin
      retain_flip <= retain_flip;
    end
  end

  // ---------------------------------------------------------------
  // Thresholds and comparison
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] set_eff;
  logic [CNT_W-1:0] clr_eff;
  logic             hyst_mode;
  logic             at_set;
  logic             below_clr;
  logic             in_window;
  logic             cmp_q;
  logic             scan_tick;

  // External thresholds are taken live from the supplying block
  assign set_eff = pick_thr(ctrl[CTRL_EXT_SET], set_thr,
                            ext_set_thr);
  assign clr_eff = pick_thr(ctrl[CTRL_EXT_CLR], clr_thr,
                            ext_clr_thr);

  assign hyst_mode = (set_eff >= clr_eff);
  assign at_set    = (count >= set_eff);
  assign below_clr = (count < clr_eff);
  assign in_window = at_set && below_clr;

  // Hysteresis mode holds between the thresholds
  // Window mode is high only inside the window
  assign cmp_q = hyst_mode ?
                 (at_set ? 1'b1 : (below_clr ? 1'b0 : switch_out)) :
                 in_window;

  // Scan cycle timer
  assign scan_tick = running && (scan_cnt == SCAN_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_cnt <= SCAN_ZERO;
    end else if (!running || scan_tick) begin
      scan_cnt <= SCAN_ZERO;
    end else begin
      scan_cnt <= scan_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  logic pulse_rise;
  logic at_top;
  logic at_bottom;

  // Rising edges only; falling edges pass unnoticed
  assign pulse_rise = pulse_lvl && !pulse_prev;
  assign at_top     = (count == CNT_MAX);
  assign at_bottom  = (count == CNT_ZERO);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= pulse_lvl;
    end
  end

  // Next count, clear first
  always_comb begin
    next_count = count;
    if (clear_lvl) begin
      next_count = CNT_ZERO;
    end else if (!running) begin
      next_count = count;
    end else if (wr_count) begin
      next_count = clamp_cnt(bus_req.wdata);
    end else if (load_start) begin
      next_count = start_val;
    end else if (pulse_rise) begin
      if (!dir_lvl) begin
        // Up, saturating at the top
        next_count = at_top ? count : count + CNT_ONE;
      end else begin
        // Down, saturating at zero
        next_count = at_bottom ? count : count - CNT_ONE;
      end
    end
  end

  // Next output: updated at a scan tick, forced low by clear
  always_comb begin
    next_q = switch_out;
    if (clear_lvl) begin
      next_q = 1'b0;
    end else if (scan_tick) begin
      next_q = cmp_q;
    end
  end

  // ---------------------------------------------------------------
  // Keep store for retention
  // ---------------------------------------------------------------
  logic              keep_wr;
  logic              keep_waddr;
  logic [KEEP_W-1:0] keep_wdata;
  logic              keep_raddr;
  logic [KEEP_W-1:0] keep_rdata;
  logic [KEEP_W-1:0] mark_word;

  // Alternate between the data word and the marker word
  assign mark_word  = retain_en ? KEEP_MARK : '0;
  assign keep_wr    = running;
  assign keep_waddr = keep_sel;
  assign keep_wdata = (keep_sel == KEEP_ADR_MARK) ?
                      mark_word : {switch_out, count};
  assign keep_raddr = (state == ST_MARK) ? KEEP_ADR_MARK : KEEP_ADR_DATA;

  udc_keep_mem #(
    .WIDTH (KEEP_W),
    .DEPTH (2),
    .AW    (1)
  ) u_keep (
    .core_clk (core_clk),
    .wr_en    (keep_wr),
    .wr_addr  (keep_waddr),
    .wr_data  (keep_wdata),
    .rd_addr  (keep_raddr),
    .rd_data  (keep_rdata)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      keep_sel <= KEEP_ADR_DATA;
    end else if (running) begin
      keep_sel <= ~keep_sel;
    end
  end

  // ---------------------------------------------------------------
  // Restore sequence after reset
  // ---------------------------------------------------------------
  always_comb begin
    unique case (state)
      ST_MARK: next_state = ST_CHK;
      ST_CHK:  next_state = ST_LOAD;
      ST_LOAD: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state   <= ST_MARK;
      mark_ok <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_CHK) begin
        // Marker alone decides: the retain bit itself is lost in reset
        mark_ok <= (keep_rdata == KEEP_MARK);
      end
    end
  end

  // Count and output registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count      <= CNT_ZERO;
      switch_out <= 1'b0;
    end else if (state == ST_LOAD) begin
      if (mark_ok && !clear_lvl) begin
        count      <= keep_rdata[CNT_W-1:0];
        switch_out <= keep_rdata[CNT_W];
      end else begin
        count      <= clear_lvl ? CNT_ZERO : start_val;
        switch_out <= 1'b0;
      end
    end else begin
      count      <= next_count;
      switch_out <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Read path and mirrored count
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rd_mux;

  assign status_word = DATA_W'({running, dir_lvl, clear_lvl, switch_out});

  always_comb begin
    unique case (bus_req.addr)
      ADR_CTRL:    rd_mux = DATA_W'(ctrl);
      ADR_SET_THR: rd_mux = DATA_W'(set_thr);
      ADR_CLR_THR: rd_mux = DATA_W'(clr_thr);
      ADR_START:   rd_mux = DATA_W'(start_val);
      ADR_COUNT:   rd_mux = DATA_W'(count);
      ADR_STATUS:  rd_mux = status_word;
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data   <= '0;
      count_out <= CNT_ZERO;
    end else begin
      rd_data   <= bus_req.rd ? rd_mux : '0;
      count_out <= next_count;
    end
  end

endmodule // udc_counter_top

// ==== rtl/udc_pkg.sv ====
// Shared constants and types for the up/down threshold counter
package udc_pkg;

  // ---------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------
  localparam int CNT_W   = 27;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int KEEP_W  = CNT_W + 1;
  localparam int PIN_W   = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 27'h0000000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 27'h5F5E0FF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_TIME_NS  = 10000000;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_SET_THR = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_CLR_THR = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_START   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADR_COUNT   = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_STATUS  = 8'h14;

  // Control fields
  localparam int CTRL_RETAIN  = 0;
  localparam int CTRL_EXT_SET = 1;
  localparam int CTRL_EXT_CLR = 2;
  localparam int CTRL_LOAD    = 3;
  localparam int CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // Status fields
  localparam int STAT_Q     = 0;
  localparam int STAT_CLEAR = 1;
  localparam int STAT_DIR   = 2;
  localparam int STAT_RUN   = 3;

  // Pin vector layout
  localparam int PIN_PULSE = 0;
  localparam int PIN_DIR   = 1;
  localparam int PIN_CLEAR = 2;

  // Keep store layout
  localparam logic KEEP_ADR_DATA = 1'h0;
  localparam logic KEEP_ADR_MARK = 1'h1;
  localparam logic [KEEP_W-1:0] KEEP_MARK = 28'h5A5C3E9;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } udc_bus_req_t;

  // Restore and run sequence
  typedef enum logic [1:0] {
    ST_MARK = 2'b00,
    ST_CHK  = 2'b01,
    ST_LOAD = 2'b10,
    ST_RUN  = 2'b11
  } udc_state_t;

endpackage

// ==== rtl/udc_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for input pins
`timescale 1ns/1ps
module udc_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] next_level;

  // Accept a change once stages two and three match
  assign agree      = ~(stage2 ^ stage3);
  assign next_level = (agree & stage3) | (~agree & level);

  // Sampling chain
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule // udc_pin_sync

// ==== rtl/udc_keep_mem.sv ====
// Small unreset store that keeps the count across resets
`timescale 1ns/1ps
module udc_keep_mem #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2,
  parameter int AW    = 1
) (
  // Clock
  input  wire logic             core_clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output      logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: contents must outlive a reset of the block
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // udc_keep_mem

// ==== dv/udc_counter_sva.sv ====
// Port-level checks for the up/down threshold counter
`timescale 1ns/1ps
module udc_counter_sva
  import udc_pkg::*;
#(
  parameter int SCAN_CYCLES = 20
) (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        reset_n,
  // Register port
  input wire udc_pkg::udc_bus_req_t       bus_req,
  input wire logic [udc_pkg::DATA_W-1:0]  rd_data,
  // Pins and supplied thresholds
  input wire logic                        pulse_in,
  input wire logic                        dir_in,
  input wire logic                        clear_in,
  input wire logic [udc_pkg::CNT_W-1:0]   ext_set_thr,
  input wire logic [udc_pkg::CNT_W-1:0]   ext_clr_thr,
  // Results
  input wire logic                        switch_out,
  input wire logic [udc_pkg::CNT_W-1:0]   count_out
);
  import udc_pkg::*;

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [3:0]  quiet;
  logic [31:0] since_rise;
  wire         calm = (quiet >= 4'h8);

  // Cycles since the last write or clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet <= 4'h0;
    end else if (bus_req.wr || clear_in) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  // Cycles since the output last rose, saturating at one scan
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_rise <= 32'(SCAN_CYCLES);
    end else if ($rose(switch_out)) begin
      since_rise <= 32'h1;
    end else if (since_rise < 32'(SCAN_CYCLES)) begin
      since_rise <= since_rise + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_clear_held; clear_in [*8]; endsequence
  sequence s_pulse_low;  !pulse_in [*8]; endsequence
  sequence s_dir_up;     !dir_in [*8]; endsequence
  sequence s_dir_down;   dir_in [*8]; endsequence

  a_rd_idle_zero: assert property (
    !$past(bus_req.rd) |-> rd_data == '0)
    else $error("read data not zero outside read cycle");
  a_clear_zero_cnt: assert property (
    s_clear_held |-> count_out == CNT_ZERO)
    else $error("count not zero while clear held");
  a_clear_low_out: assert property (
    s_clear_held |-> !switch_out)
    else $error("output high while clear held");
  a_step_one: assert property (
    calm |-> count_out == $past(count_out)
      || count_out == $past(count_out) + 27'h0000001
      || count_out == $past(count_out) - 27'h0000001)
    else $error("count moved by more than one");
  a_no_wrap_zero: assert property (
    calm && $past(count_out) == CNT_ZERO |-> count_out <= 27'h0000001)
    else $error("count wrapped below zero");
  a_max_bound: assert property (
    count_out <= CNT_MAX)
    else $error("count above maximum");
  a_dir_up_only: assert property (
    s_dir_up ##0 calm |-> count_out >= $past(count_out))
    else $error("count fell while counting up");
  a_dir_down_only: assert property (
    s_dir_down ##0 calm |-> count_out <= $past(count_out))
    else $error("count rose while counting down");
  a_fall_no_count: assert property (
    s_pulse_low ##0 calm |-> $stable(count_out))
    else $error("count changed with pulse low");
  a_rise_on_tick: assert property (
    $rose(switch_out) |-> since_rise >= SCAN_CYCLES)
    else $error("output rose twice within one scan");

endmodule // udc_counter_sva

bind udc_counter_top udc_counter_sva #(.SCAN_CYCLES(SCAN_CYCLES)) u_sva (
  .core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
  .rd_data(rd_data), .pulse_in(pulse_in), .dir_in(dir_in),
  .clear_in(clear_in), .ext_set_thr(ext_set_thr),
  .ext_clr_thr(ext_clr_thr), .switch_out(switch_out),
  .count_out(count_out)
);

// ==== dv/udc_pin_model.sv ====
// Partner model: input pins and a threshold-supplying block
`timescale 1ns/1ps
module udc_pin_model
  import udc_pkg::*;
(
  // Clock
  input wire logic                   core_clk,
  // Pins toward the counter
  output     logic                   pulse_in,
  output     logic                   dir_in,
  output     logic                   clear_in,
  // Thresholds from another block
  output     logic [udc_pkg::CNT_W-1:0] ext_set_thr,
  output     logic [udc_pkg::CNT_W-1:0] ext_clr_thr
);
  import udc_pkg::*;

  // Idle levels from time zero
  initial begin
    pulse_in    = 1'b0;
    dir_in      = 1'b0;
    clear_in    = 1'b0;
    ext_set_thr = '0;
    ext_clr_thr = '0;
  end

  // Burst of pulses, fast or slow, after direction settles
  task automatic pulses(input int n, input logic down, input logic slow);
    int h;
    h = slow ? 8 : 3;
    @(posedge core_clk);
    dir_in <= down;
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      pulse_in <= 1'b1;
      repeat (h) @(posedge core_clk);
      pulse_in <= 1'b0;
      repeat (h) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
  endtask

  // Clear level, held until it has passed the input filter
  task automatic set_clear(input logic v);
    @(posedge core_clk);
    clear_in <= v;
    repeat (8) @(posedge core_clk);
  endtask

  // Supplying block presents its current values
  task automatic present(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] c);
    @(posedge core_clk);
    ext_set_thr <= s;
    ext_clr_thr <= c;
  endtask

endmodule // udc_pin_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the up/down threshold counter
`timescale 1ns/1ps
module tb_top
  import udc_pkg::*;
;
  localparam int SCAN = 20;
  logic                 core_clk;
  logic                 reset_n;
  udc_bus_req_t         bus_req;
  logic [DATA_W-1:0]    rd_data;
  logic                 pulse_in;
  logic                 dir_in;
  logic                 clear_in;
  logic                 switch_out;
  logic [CNT_W-1:0]     ext_set_thr;
  logic [CNT_W-1:0]     ext_clr_thr;
  logic [CNT_W-1:0]     count_out;
  logic [ADDR_W-1:0]    zero_regs [5];
  int                   err_total;
  int                   n_compared;

  // Clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  udc_counter_top #(.SCAN_CYCLES(SCAN)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .pulse_in(pulse_in), .dir_in(dir_in),
    .clear_in(clear_in), .ext_set_thr(ext_set_thr),
    .ext_clr_thr(ext_clr_thr), .switch_out(switch_out),
    .count_out(count_out)
  );

  udc_pin_model u_pins (
    .core_clk(core_clk), .pulse_in(pulse_in), .dir_in(dir_in),
    .clear_in(clear_in), .ext_set_thr(ext_set_thr),
    .ext_clr_thr(ext_clr_thr)
  );

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic w);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    #1 chk(rd_data, e);
  endtask

  // Thresholds and count, then look after two scan ticks
  task automatic thr(input logic ext, input logic [CNT_W-1:0] s,
                     input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] v,
                     input logic e);
    if (ext) begin
      u_pins.present(s, c);
      wr(ADR_CTRL, 32'h6);
    end else begin
      wr(ADR_CTRL, 32'h0);
      wr(ADR_SET_THR, 32'(s));
      wr(ADR_CLR_THR, 32'(c));
    end
    wr(ADR_COUNT, 32'(v));
    repeat (2 * SCAN + 8) @(posedge core_clk);
    #1 chk({31'h0, switch_out}, {31'h0, e});
  endtask

  // Reset pulse in mid-run
  task automatic reset_pulse;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence of tests
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    err_total = 0;
    n_compared = 0;
    zero_regs = '{ADR_CTRL, ADR_SET_THR, ADR_CLR_THR, ADR_START, 8'h20};
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    // Reset values, unmapped place, read-only status
    foreach (zero_regs[i]) rd(zero_regs[i], 32'h0);
    rd(ADR_STATUS, 32'h8);
    wr(ADR_STATUS, 32'hF);
    // First scan tick has passed: zero thresholds set the output
    rd(ADR_STATUS, 32'h9);
    // Start value, counting both ways
    wr(ADR_START, 32'hA);
    wr(ADR_CTRL, 32'h8);
    rd(ADR_COUNT, 32'hA);
    u_pins.pulses(5, 1'b0, 1'b0);
    rd(ADR_COUNT, 32'hF);
    chk(32'(count_out), 32'hF);
    u_pins.pulses(3, 1'b1, 1'b1);
    rd(ADR_COUNT, 32'hC);
    // Saturation at both ends and clamped write
    wr(ADR_COUNT, 32'h05F5E0FF);
    u_pins.pulses(1, 1'b0, 1'b0);
    rd(ADR_COUNT, 32'h05F5E0FF);
    wr(ADR_COUNT, 32'h07FFFFFF);
    rd(ADR_COUNT, 32'h05F5E0FF);
    wr(ADR_COUNT, 32'h0);
    u_pins.pulses(1, 1'b1, 1'b0);
    rd(ADR_COUNT, 32'h0);
    // Hysteresis, window and supplied thresholds
    thr(1'b0, 27'd20, 27'd5, 27'd4, 1'b0);
    thr(1'b0, 27'd20, 27'd5, 27'd12, 1'b0);
    thr(1'b0, 27'd20, 27'd5, 27'd20, 1'b1);
    thr(1'b0, 27'd20, 27'd5, 27'd10, 1'b1);
    thr(1'b0, 27'd20, 27'd5, 27'd5, 1'b1);
    thr(1'b0, 27'd20, 27'd5, 27'd4, 1'b0);
    thr(1'b0, 27'd5, 27'd10, 27'd4, 1'b0);
    thr(1'b0, 27'd5, 27'd10, 27'd5, 1'b1);
    thr(1'b0, 27'd5, 27'd10, 27'd9, 1'b1);
    thr(1'b0, 27'd5, 27'd10, 27'd10, 1'b0);
    thr(1'b1, 27'd50, 27'd60, 27'd55, 1'b1);
    thr(1'b1, 27'd50, 27'd60, 27'd61, 1'b0);
    thr(1'b1, 27'd60, 27'd60, 27'd60, 1'b1);
    // Clear wins over a high output and over pulses
    u_pins.set_clear(1'b1);
    #1 chk({31'h0, switch_out}, 32'h0);
    u_pins.pulses(2, 1'b0, 1'b0);
    rd(ADR_COUNT, 32'h0);
    rd(ADR_STATUS, 32'hA);
    u_pins.set_clear(1'b0);
    rd(ADR_COUNT, 32'h0);
    // Retention on keeps the count, off reinitialises it
    wr(ADR_CTRL, 32'h1);
    wr(ADR_COUNT, 32'd33);
    repeat (10) @(posedge core_clk);
    reset_pulse();
    rd(ADR_COUNT, 32'd33);
    chk(32'(count_out), 32'd33);
    wr(ADR_COUNT, 32'd44);
    repeat (10) @(posedge core_clk);
    reset_pulse();
    rd(ADR_COUNT, 32'h0);
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

endmodule // tb_top
